// ---- core/ssi_consts.svh ----
// Purpose: register offsets, field positions and reset values of the status and interrupt summary block
// Assumes: byte-wide registers on the host register port
// Notes:   definitions only
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

`define SSI_ADDR_ID_HIGH     8'h30
`define SSI_ADDR_ID_LOW_REV  8'h31
`define SSI_ADDR_CFG_STRAP   8'h40
`define SSI_ADDR_PIN_LEVEL   8'h41
`define SSI_ADDR_TOP_IRQ     8'h42
`define SSI_ADDR_GLOBAL_FUNCTIONS_SUMMARY_IRQ    8'h43
`define SSI_ADDR_INPUT_IRQ   8'h44

`define SSI_CFG_TEST_BIT     3'd7
`define SSI_CFG_OSCILLATOR_FAIL_FLAG_BIT   3'd6
`define SSI_CFG_IF_LSB       3'd2
`define SSI_CFG_AC_LSB       3'd0

`define SSI_ID_LOW_LSB       3'd4
`define SSI_REV_LSB          3'd0

`define SSI_TOP_GLOBAL_FUNCTIONS_SUMMARY_BIT     3'd6
`define SSI_TOP_OC_BIT       3'd5
`define SSI_TOP_IC_BIT       3'd4
`define SSI_TOP_DPLL_BIT     3'd3
`define SSI_TOP_APLL_BIT     3'd2
`define SSI_TOP_EN_BIT       3'd1
`define SSI_TOP_INT_BIT      3'd0

`define SSI_GLOBAL_FUNCTIONS_SUMMARY_BOOT_BIT    3'd7
`define SSI_GLOBAL_FUNCTIONS_SUMMARY_PA_BIT      3'd1
`define SSI_GLOBAL_FUNCTIONS_SUMMARY_MAB_BIT     3'd0

`define SSI_IC1_BIT          3'd0
`define SSI_IC2_BIT          3'd1
`define SSI_IC3_BIT          3'd2

`define SSI_BYTE_ZERO        8'h00
`define SSI_EN_RESET         1'b0
`define SSI_FLAG_RESET       1'b0

`endif

// ---- core/ssi_pkg.sv ----
// Purpose: shared types of the status and interrupt summary block
// Assumes: nothing beyond the constants header
// Notes:   nothing is imported; users write ssi_pkg::name
package ssi_pkg;
    typedef logic [7:0] ssi_byte_t;
    typedef logic [1:0] ssi_strap2_t;
    typedef logic [3:0] ssi_pin_t;
endpackage : ssi_pkg

// ---- core/ssi_status_irq.sv ----
// Purpose: identity, strap status, pin levels and the two-level interrupt summary tree
// Assumes: one clock, synchronous active-low reset; host serial decoder gives byte reads and writes
// Notes:   straps and pins come from package pins and are synchronised before use
//
// How it works
// - identity high byte reads at 0x30, read only.
// - identity low four bits sit in bits 7..4 of 0x31.
// - bits 3..0 of 0x31 give silicon revision, starting at zero.
// - test strap bit holds test pin level caught at reset release.
// - oscillator fail bit follows monitor, forced zero when ring oscillator disabled.
// - interface strap field holds two select pins caught at reset release.
// - auto-configuration strap field holds two config pins caught at reset release.
// - pin status low nibble shows live pin levels, no inversion.
// - global summary bit set when phase adjust or phase measure bit set; boot done not included.
// - output clock summary set when any output clock interrupt bit set.
// - input clock summary set when any input clock interrupt bit set.
// - digital loop summary set when any digital loop interrupt bit set.
// - analog loop summary set when any analog loop interrupt bit set.
// - writable master enable; zero blocks every source from master status.
// - master status equals OR of five summaries ANDed with enable.
// - a chosen pin may be driven to follow master status.
// - boot done clears on reset, sets when boot controller finishes.
// - phase adjust bit set while any latched-and-enabled phase adjust status.
// - phase measure bit set while any latched-and-enabled measure status.
// - third input bit set while its latched validity and enable set.
// - second input bit set while its latched validity and enable set.
// - first input bit set while its latched validity and enable set.
// - latched bits set on any live change; a one on the matching clear input clears them.
`timescale 1ns/1ps
`include "ssi_consts.svh"

module ssi_status_irq #(
    parameter int                 PA_W   = 4,
    parameter int                 MAB_W  = 2,
    parameter logic [7:0]         ID_HIGH = 8'ha5,   // arbitrary value
    parameter logic [3:0]         ID_LOW  = 4'h6,    // arbitrary value
    parameter logic [3:0]         SILICON_REVISION_FIELD     = 4'h0
) (
    input  wire logic             I_CLK_SYS,
    input  wire logic             I_RESETN,
    input  wire logic [7:0]       I_REG_ADDR,
    input  wire logic             I_REG_RD,
    input  wire logic             I_REG_WR,
    input  wire logic [7:0]       I_REG_WDATA,
    output logic      [7:0]       O_REG_RDATA,
    output logic                  O_REG_RVALID,
    input  wire logic             I_PIN_TEST,
    input  wire logic [1:0]       I_PIN_IF_SEL,
    input  wire logic [1:0]       I_PIN_AC_SEL,
    input  wire logic [3:0]       I_PIN_GPIO,
    input  wire logic             I_XO_FAIL,
    input  wire logic             I_RING_OSC_DISABLE,
    input  wire logic             I_BOOT_DONE,
    input  wire logic [PA_W-1:0]  I_PA_RT,
    input  wire logic [PA_W-1:0]  I_PA_IE,
    input  wire logic [PA_W-1:0]  I_PA_CLR,
    input  wire logic [MAB_W-1:0] I_MAB_RT,
    input  wire logic [MAB_W-1:0] I_MAB_IE,
    input  wire logic [MAB_W-1:0] I_MAB_CLR,
    input  wire logic [2:0]       I_VAL_RT,
    input  wire logic [2:0]       I_VAL_IE,
    input  wire logic [2:0]       I_VAL_CLR,
    input  wire logic [7:0]       I_OC_ISR,
    input  wire logic [7:0]       I_DPLL_ISR,
    input  wire logic [7:0]       I_APLL_ISR,
    input  wire logic             I_IRQ_PIN_EN,
    input  wire logic [1:0]       I_IRQ_PIN_SEL,
    output logic      [3:0]       O_GPIO_OUT,
    output logic      [3:0]       O_GPIO_OE,
    output logic                  O_IRQ,
    output logic      [PA_W-1:0]  O_PA_LATCHED,
    output logic      [MAB_W-1:0] O_MAB_LATCHED,
    output logic      [2:0]       O_VAL_LATCHED
);

    localparam int LEAF_W = 3 + MAB_W + PA_W;

    // pin synchronisers: stage one is read only by stage two
    logic                 test_s1_reg;
    logic                 test_s2_reg;
    ssi_pkg::ssi_strap2_t if_s1_reg;
    ssi_pkg::ssi_strap2_t if_s2_reg;
    ssi_pkg::ssi_strap2_t ac_s1_reg;
    ssi_pkg::ssi_strap2_t ac_s2_reg;
    ssi_pkg::ssi_pin_t    gpio_s1_reg;
    ssi_pkg::ssi_pin_t    gpio_s2_reg;

    logic                 strap_done_reg;
    logic                 strap_test_reg;
    ssi_pkg::ssi_strap2_t strap_if_reg;
    ssi_pkg::ssi_strap2_t strap_ac_reg;
    logic                 boot_done_reg;
    logic                 irq_en_reg;

    logic [LEAF_W-1:0]    leaf_rt;
    logic [LEAF_W-1:0]    leaf_ie;
    logic [LEAF_W-1:0]    leaf_clr;
    logic [LEAF_W-1:0]    leaf_prev_reg;
    logic [LEAF_W-1:0]    leaf_lat_reg;
    logic [LEAF_W-1:0]    leaf_act;

    logic                 pa_irq;
    logic                 mab_irq;
    logic [2:0]           input_irq;
    logic                 global_functions_summary_sum;
    logic                 oc_sum;
    logic                 ic_sum;
    logic                 dpll_sum;
    logic                 apll_sum;
    logic                 master_irq;
    logic                 xo_fail_bit;

    ssi_pkg::ssi_byte_t   cfg_byte;
    ssi_pkg::ssi_byte_t   top_byte;
    ssi_pkg::ssi_byte_t   global_functions_summary_byte;
    ssi_pkg::ssi_byte_t   input_byte;
    ssi_pkg::ssi_byte_t   rdata_next;

    // no reset on the synchronisers so the straps are already valid when reset lifts
    always_ff @(posedge I_CLK_SYS) begin
        test_s1_reg <= I_PIN_TEST;
        test_s2_reg <= test_s1_reg;
        if_s1_reg   <= I_PIN_IF_SEL;
        if_s2_reg   <= if_s1_reg;
        ac_s1_reg   <= I_PIN_AC_SEL;
        ac_s2_reg   <= ac_s1_reg;
        gpio_s1_reg <= I_PIN_GPIO;
        gpio_s2_reg <= gpio_s1_reg;
    end

    // straps are caught on the first edge after reset release, then frozen
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            strap_done_reg <= `SSI_FLAG_RESET;
            strap_test_reg <= `SSI_FLAG_RESET;
            strap_if_reg   <= '0;
            strap_ac_reg   <= '0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_test_reg <= test_s2_reg;
            strap_if_reg   <= if_s2_reg;
            strap_ac_reg   <= ac_s2_reg;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            boot_done_reg <= `SSI_FLAG_RESET;
        end else if (I_BOOT_DONE) begin
            boot_done_reg <= 1'b1;
        end
    end

    // the only writable bit of the whole group; every other write is dropped
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            irq_en_reg <= `SSI_EN_RESET;
        end else if (I_REG_WR && I_REG_ADDR == `SSI_ADDR_TOP_IRQ) begin
            irq_en_reg <= I_REG_WDATA[`SSI_TOP_EN_BIT];
        end
    end

    assign leaf_rt  = {I_PA_RT, I_MAB_RT, I_VAL_RT};
    assign leaf_ie  = {I_PA_IE, I_MAB_IE, I_VAL_IE};
    assign leaf_clr = {I_PA_CLR, I_MAB_CLR, I_VAL_CLR};

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            leaf_prev_reg <= '0;
        end else begin
            leaf_prev_reg <= leaf_rt;
        end
    end

    // a change in the same cycle as a clear keeps the bit set
    genvar gi;
    generate
        for (gi = 0; gi < LEAF_W; gi++) begin : g_leaf
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RESETN) begin
                    leaf_lat_reg[gi] <= `SSI_FLAG_RESET;
                end else begin
                    leaf_lat_reg[gi] <= (leaf_rt[gi] ^ leaf_prev_reg[gi]) |
                                        (leaf_lat_reg[gi] & ~leaf_clr[gi]);
                end
            end
            assign leaf_act[gi] = leaf_lat_reg[gi] & leaf_ie[gi];
        end
    endgenerate

    assign input_irq  = leaf_act[2:0];
    assign mab_irq    = |leaf_act[3 +: MAB_W];
    assign pa_irq     = |leaf_act[3 + MAB_W +: PA_W];
    assign global_functions_summary_sum   = pa_irq | mab_irq;
    assign oc_sum     = |I_OC_ISR;
    assign ic_sum     = |input_irq;
    assign dpll_sum   = |I_DPLL_ISR;
    assign apll_sum   = |I_APLL_ISR;
    assign master_irq = (global_functions_summary_sum | oc_sum | ic_sum | dpll_sum | apll_sum) & irq_en_reg;
    assign xo_fail_bit = I_XO_FAIL & ~I_RING_OSC_DISABLE;

    always_comb begin
        cfg_byte                             = `SSI_BYTE_ZERO;
        cfg_byte[`SSI_CFG_TEST_BIT]          = strap_test_reg;
        cfg_byte[`SSI_CFG_OSCILLATOR_FAIL_FLAG_BIT]        = xo_fail_bit;
        cfg_byte[`SSI_CFG_IF_LSB +: 2]       = strap_if_reg;
        cfg_byte[`SSI_CFG_AC_LSB +: 2]       = strap_ac_reg;
        top_byte                             = `SSI_BYTE_ZERO;
        top_byte[`SSI_TOP_GLOBAL_FUNCTIONS_SUMMARY_BIT]          = global_functions_summary_sum;
        top_byte[`SSI_TOP_OC_BIT]            = oc_sum;
        top_byte[`SSI_TOP_IC_BIT]            = ic_sum;
        top_byte[`SSI_TOP_DPLL_BIT]          = dpll_sum;
        top_byte[`SSI_TOP_APLL_BIT]          = apll_sum;
        top_byte[`SSI_TOP_EN_BIT]            = irq_en_reg;
        top_byte[`SSI_TOP_INT_BIT]           = master_irq;
        global_functions_summary_byte                            = `SSI_BYTE_ZERO;
        global_functions_summary_byte[`SSI_GLOBAL_FUNCTIONS_SUMMARY_BOOT_BIT]        = boot_done_reg;
        global_functions_summary_byte[`SSI_GLOBAL_FUNCTIONS_SUMMARY_PA_BIT]          = pa_irq;
        global_functions_summary_byte[`SSI_GLOBAL_FUNCTIONS_SUMMARY_MAB_BIT]         = mab_irq;
        input_byte                           = `SSI_BYTE_ZERO;
        input_byte[`SSI_IC1_BIT]             = input_irq[0];
        input_byte[`SSI_IC2_BIT]             = input_irq[1];
        input_byte[`SSI_IC3_BIT]             = input_irq[2];
    end

    always_comb begin
        if (I_REG_ADDR == `SSI_ADDR_ID_HIGH) begin
            rdata_next = ID_HIGH;
        end else if (I_REG_ADDR == `SSI_ADDR_ID_LOW_REV) begin
            rdata_next = `SSI_BYTE_ZERO;
            rdata_next[`SSI_ID_LOW_LSB +: 4] = ID_LOW;
            rdata_next[`SSI_REV_LSB +: 4]    = SILICON_REVISION_FIELD;
        end else if (I_REG_ADDR == `SSI_ADDR_CFG_STRAP) begin
            rdata_next = cfg_byte;
        end else if (I_REG_ADDR == `SSI_ADDR_PIN_LEVEL) begin
            rdata_next = {4'h0, gpio_s2_reg};
        end else if (I_REG_ADDR == `SSI_ADDR_TOP_IRQ) begin
            rdata_next = top_byte;
        end else if (I_REG_ADDR == `SSI_ADDR_GLOBAL_FUNCTIONS_SUMMARY_IRQ) begin
            rdata_next = global_functions_summary_byte;
        end else if (I_REG_ADDR == `SSI_ADDR_INPUT_IRQ) begin
            rdata_next = input_byte;
        end else begin
            rdata_next = `SSI_BYTE_ZERO;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_REG_RDATA  <= `SSI_BYTE_ZERO;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= rdata_next;
            end
        end
    end

    // interrupt pin drive is registered so the pin never glitches on summary decode
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
            O_IRQ      <= 1'b0;
            O_GPIO_OUT <= 4'h0;
            O_GPIO_OE  <= 4'h0;
        end else begin
            O_IRQ      <= master_irq;
            O_GPIO_OUT <= master_irq ? (4'h1 << I_IRQ_PIN_SEL) : 4'h0;
            O_GPIO_OE  <= I_IRQ_PIN_EN ? (4'h1 << I_IRQ_PIN_SEL) : 4'h0;
        end
    end

    assign O_VAL_LATCHED = leaf_lat_reg[2:0];
    assign O_MAB_LATCHED = leaf_lat_reg[3 +: MAB_W];
    assign O_PA_LATCHED  = leaf_lat_reg[3 + MAB_W +: PA_W];

    property p_id_high;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_RD && I_REG_ADDR == `SSI_ADDR_ID_HIGH |=> O_REG_RVALID && O_REG_RDATA == ID_HIGH;
    endproperty
    a_id_high: assert property (p_id_high) else $error("identity high byte wrong");

    property p_id_low_rev;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_RD && I_REG_ADDR == `SSI_ADDR_ID_LOW_REV |=> O_REG_RDATA == {ID_LOW, SILICON_REVISION_FIELD};
    endproperty
    a_id_low_rev: assert property (p_id_low_rev) else $error("identity low or revision wrong");

    property p_strap_frozen;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        strap_done_reg |=> $stable(strap_test_reg) && $stable(strap_if_reg) && $stable(strap_ac_reg);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed after capture");

    property p_xo_masked;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_RD && I_REG_ADDR == `SSI_ADDR_CFG_STRAP && I_RING_OSC_DISABLE |=> !O_REG_RDATA[`SSI_CFG_OSCILLATOR_FAIL_FLAG_BIT];
    endproperty
    a_xo_masked: assert property (p_xo_masked) else $error("oscillator fail shown while ring oscillator off");

    property p_pin_level;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_RD && I_REG_ADDR == `SSI_ADDR_PIN_LEVEL |=> O_REG_RDATA == {4'h0, $past(gpio_s2_reg)};
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin status mismatch");

    property p_master;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        ##1 O_IRQ == ($past(irq_en_reg) &&
            ($past(|I_OC_ISR) || $past(|I_DPLL_ISR) || $past(|I_APLL_ISR) || $past(|leaf_act)));
    endproperty
    a_master: assert property (p_master) else $error("master status not OR of summaries and enable");

    property p_enable_write;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_WR && I_REG_ADDR == `SSI_ADDR_TOP_IRQ |=> irq_en_reg == $past(I_REG_WDATA[`SSI_TOP_EN_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_disabled_quiet;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        !irq_en_reg |=> !O_IRQ && O_GPIO_OUT == 4'h0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("interrupt while disabled");

    property p_boot_sticky;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        $rose(boot_done_reg) |-> $past(I_BOOT_DONE) ##1 boot_done_reg [*2];
    endproperty
    a_boot_sticky: assert property (p_boot_sticky) else $error("boot done not sticky");

    property p_leaf_change;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        (leaf_rt[0] != leaf_prev_reg[0]) ##1 (leaf_rt[0] == leaf_prev_reg[0] && !leaf_clr[0])[*2] |-> leaf_lat_reg[0];
    endproperty
    a_leaf_change: assert property (p_leaf_change) else $error("input change not latched");

    property p_leaf_input_irq;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_RD && I_REG_ADDR == `SSI_ADDR_INPUT_IRQ |=>
            O_REG_RDATA[2:0] == ($past(leaf_lat_reg[2:0]) & $past(I_VAL_IE));
    endproperty
    a_leaf_input_irq: assert property (p_leaf_input_irq) else $error("input interrupt bits wrong");

    property p_global_functions_summary_bits;
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        I_REG_RD && I_REG_ADDR == `SSI_ADDR_GLOBAL_FUNCTIONS_SUMMARY_IRQ |=>
            O_REG_RDATA[`SSI_GLOBAL_FUNCTIONS_SUMMARY_PA_BIT] == $past(|(O_PA_LATCHED & I_PA_IE)) &&
            O_REG_RDATA[`SSI_GLOBAL_FUNCTIONS_SUMMARY_MAB_BIT] == $past(|(O_MAB_LATCHED & I_MAB_IE));
    endproperty
    a_global_functions_summary_bits: assert property (p_global_functions_summary_bits) else $error("global interrupt bits wrong");

    c_boot_then_irq: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) boot_done_reg ##[1:20] O_IRQ);
    c_irq_on_pin:    cover property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) I_IRQ_PIN_EN && O_GPIO_OUT != 4'h0);
    c_set_vs_clear:  cover property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
                                     leaf_clr[0] && leaf_rt[0] != leaf_prev_reg[0]);

endmodule : ssi_status_irq

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the status and interrupt summary block
// Assumes: read data one cycle after each read edge; leaf latch set wins over clear; oscillator fail read live
// Notes:   cycle-exact reference model; random stimulus from a shift register seeded with 53
`timescale 1ns/1ps
`include "ssi_consts.svh"

module tb;
    localparam logic [7:0] TB_ID_H = 8'h3c;   // arbitrary value
    localparam logic [3:0] TB_ID_L = 4'h9;    // arbitrary value
    localparam logic [3:0] TB_REV  = 4'h0;
    localparam int         LIMIT   = 20000;
    logic       clk = 1'b0, reset_pin_low_active = 1'b0, rd = 1'b0, wr = 1'b0, boot = 1'b0, xo = 1'b0, rosc = 1'b0;
    logic       ptest = 1'b0, pin_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, oc = 8'h00, dp = 8'h00, ap = 8'h00;
    logic [1:0] pif = 2'h2, pac = 2'h1, mab_rt = 2'h0, mab_ie = 2'h0, mab_clr = 2'h0, pin_sel = 2'h0;
    logic [3:0] gpio = 4'h0, pa_rt = 4'h0, pa_ie = 4'h0, pa_clr = 4'h0;
    logic [2:0] val_rt = 3'h0, val_ie = 3'h0, val_clr = 3'h0;
    wire  [7:0] rdata;
    wire  [3:0] gout, goe, pa_l;
    wire  [1:0] mab_l;
    wire  [2:0] val_l;
    wire        rvalid, irq;
    logic [31:0] seed = 32'd53;
    int          fails = 0, check_count = 0, cyc = 0;
    logic [7:0] addr_tab [8] = '{8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
    // reference model state
    logic [3:0] m_pa = 4'h0, m_pa_p = 4'h0, g1 = 4'h0, g2 = 4'h0, m_gout = 4'h0, m_goe = 4'h0;
    logic [1:0] m_mab = 2'h0, m_mab_p = 2'h0;
    logic [2:0] m_val = 3'h0, m_val_p = 3'h0;
    logic       m_en = 1'b0, m_boot = 1'b0, m_cap = 1'b0, m_rv = 1'b0, m_irq = 1'b0;
    logic [7:0] m_cfg = 8'h00, m_rd = 8'h00, m_aq = 8'h00;
    logic       s_global_functions_summary, s_ic, s_oc, s_dp, s_ap, m_int;

    ssi_status_irq #(.PA_W(4), .MAB_W(2), .ID_HIGH(TB_ID_H), .ID_LOW(TB_ID_L), .SILICON_REVISION_FIELD(TB_REV)) u_dut (
        .I_CLK_SYS(clk), .I_RESETN(reset_pin_low_active), .I_REG_ADDR(addr), .I_REG_RD(rd), .I_REG_WR(wr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_PIN_TEST(ptest),
        .I_PIN_IF_SEL(pif), .I_PIN_AC_SEL(pac), .I_PIN_GPIO(gpio), .I_XO_FAIL(xo),
        .I_RING_OSC_DISABLE(rosc), .I_BOOT_DONE(boot), .I_PA_RT(pa_rt), .I_PA_IE(pa_ie),
        .I_PA_CLR(pa_clr), .I_MAB_RT(mab_rt), .I_MAB_IE(mab_ie), .I_MAB_CLR(mab_clr),
        .I_VAL_RT(val_rt), .I_VAL_IE(val_ie), .I_VAL_CLR(val_clr), .I_OC_ISR(oc), .I_DPLL_ISR(dp),
        .I_APLL_ISR(ap), .I_IRQ_PIN_EN(pin_en), .I_IRQ_PIN_SEL(pin_sel), .O_GPIO_OUT(gout),
        .O_GPIO_OE(goe), .O_IRQ(irq), .O_PA_LATCHED(pa_l), .O_MAB_LATCHED(mab_l), .O_VAL_LATCHED(val_l));

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'hd0000001 : 32'h0);
    endfunction : lfsr

    always_comb begin
        s_global_functions_summary = |(m_pa & pa_ie) | |(m_mab & mab_ie);
        s_ic   = |(m_val & val_ie);
        s_oc   = |oc;
        s_dp   = |dp;
        s_ap   = |ap;
        m_int  = (s_global_functions_summary | s_ic | s_oc | s_dp | s_ap) & m_en;
    end

    // the model keeps its own copy of every latch; nothing is read back from the design
    always @(posedge clk) begin
        g1 <= gpio;
        g2 <= g1;
        if (!reset_pin_low_active) begin
            {m_pa, m_pa_p, m_mab, m_mab_p, m_val, m_val_p} <= '0;
            {m_en, m_boot, m_cap, m_rv, m_irq, m_cfg, m_rd, m_gout, m_goe} <= '0;
        end else begin
            m_pa <= (m_pa & ~pa_clr) | (pa_rt ^ m_pa_p);
            m_mab <= (m_mab & ~mab_clr) | (mab_rt ^ m_mab_p);
            m_val <= (m_val & ~val_clr) | (val_rt ^ m_val_p);
            {m_pa_p, m_mab_p, m_val_p} <= {pa_rt, mab_rt, val_rt};
            if (wr && addr == 8'h42) m_en <= wdata[1];
            if (boot) m_boot <= 1'b1;
            if (!m_cap) m_cfg <= {ptest, 3'h0, pif, pac};
            m_cap <= 1'b1;
            m_rv <= rd;
            m_irq <= m_int;
            m_gout <= {3'h0, m_int} << pin_sel;
            m_goe <= pin_en ? (4'h1 << pin_sel) : 4'h0;
            if (rd) begin
                m_aq <= addr;
                case (addr)
                    8'h30: m_rd <= TB_ID_H;
                    8'h31: m_rd <= {TB_ID_L, TB_REV};
                    8'h40: m_rd <= m_cfg | {1'b0, xo & ~rosc, 6'h0};
                    8'h41: m_rd <= {4'h0, g2};
                    8'h42: m_rd <= {1'b0, s_global_functions_summary, s_oc, s_ic, s_dp, s_ap, m_en, m_int};
                    8'h43: m_rd <= {m_boot, 5'h0, |(m_pa & pa_ie), |(m_mab & mab_ie)};
                    8'h44: m_rd <= {5'h0, m_val & val_ie};
                    default: m_rd <= 8'h00;
                endcase
            end
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic check_all();
        chk("rvalid", {7'h0, m_rv}, {7'h0, rvalid});
        if (m_rv) begin
            case (m_aq)
                8'h30, 8'h31: chk("identity", m_rd, rdata);
                8'h40: chk("strap_status", m_rd, rdata);
                8'h41: chk("pin_level", m_rd, rdata);
                8'h42: chk("top_summary", m_rd, rdata);
                8'h43: chk("global_irq", m_rd, rdata);
                8'h44: chk("input_irq", m_rd, rdata);
                default: chk("unmapped", m_rd, rdata);
            endcase
        end
        chk("irq", {7'h0, m_irq}, {7'h0, irq});
        chk("gpio_oe", {4'h0, m_goe}, {4'h0, goe});
        chk("gpio_out", {4'h0, m_gout}, {4'h0, gout});
        chk("leaf_latched", {m_val, m_mab, m_pa[2:0]}, {val_l, mab_l, pa_l[2:0]});
        chk("pa_latched_top", {7'h0, m_pa[3]}, {7'h0, pa_l[3]});
    endtask : check_all

    task automatic drive_random(input int n);
        logic [31:0] a, b;
        seed = lfsr(seed);
        a = seed;
        seed = lfsr(seed);
        b = seed;
        rd = a[0];
        wr = a[1] & a[2];
        addr = addr_tab[a[5:3]];
        wdata = b[7:0];
        pa_rt = pa_rt ^ (a[9:6] & b[11:8] & a[13:10]);
        mab_rt = mab_rt ^ (a[15:14] & b[13:12]);
        val_rt = val_rt ^ (a[18:16] & b[16:14] & a[21:19]);
        pa_clr = a[13:10] & b[20:17];
        mab_clr = a[23:22] & b[22:21];
        val_clr = a[21:19] & b[25:23];
        if (a[31:29] == 3'h0) {pa_ie, mab_ie, val_ie} = b[31:23];
        if (a[28:26] == 3'h0) {oc, dp, ap} = {7'h0, b[26], 7'h0, b[27], 7'h0, b[28]};
        if (a[25:24] == 2'h0) {pin_en, pin_sel, xo, rosc} = b[6:2];
        gpio = b[11:8];
        {ptest, pif, pac} = b[20:16];           // strap pins move after release
        boot = (n == 500);
    endtask : drive_random

    task automatic run_phase(input int n_cycles);
        for (int n = 0; n < n_cycles; n++) begin
            @(negedge clk);
            check_all();
            drive_random(n);
        end
    endtask : run_phase

    task automatic final_report();
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (4) @(negedge clk);
        reset_pin_low_active = 1'b1;
        run_phase(4000);
        // let the last random stimulus meet one edge so no input is driven twice in one step
        @(negedge clk);
        check_all();
        // second reset in mid-run with new strap levels held steady for the synchronisers
        {rd, wr, boot, ptest, pif, pac} = {3'h0, 1'b1, 2'h1, 2'h3};
        reset_pin_low_active = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            check_all();
        end
        reset_pin_low_active = 1'b1;
        run_phase(4000);
        final_report();
    end
endmodule : tb
